// >>> lds_top.v
/*
 Link delay supervisor: delay change detection, hold timer, bias slope,
 link integrity watchdog, latched protocol and live rate and N configuration.
 Assumes synchronous inputs and one message at most per clock.
*/
`timescale 1ns/1ps
`include "lds_defs.vh"
module lds_top #(
    parameter W = `LDS_TIME_W,
    parameter [`LDS_HOLD_W-1:0] HOLD_CYC = `LDS_HOLD_CYC_DEF,
    parameter [`LDS_HOLD_W-1:0] LINK_TO_CYC = `LDS_LINK_TO_US * `LDS_CLK_MHZ
) (
    // Clock and reset
    input wire clk,
    input wire resetn,
    // Received message
    input wire msg_valid,
    input wire [W-1:0] forward_transit_time,
    input wire [W-1:0] return_transit_time,
    input wire chan_fail,
    input wire ext_sync,
    // Settings
    input wire [W-1:0] delay_threshold_us,
    input wire [`LDS_HOLD_W-1:0] hold_cycles,
    input wire [`LDS_SLOPE_W-1:0] normal_bias_slope,
    input wire rate_sel,
    input wire proto_sel,
    input wire [3:0] mux_n_sel,
    input wire [3:0] mux_n_detect,
    // Status
    output reg [W-1:0] prop_delay_ff,
    output reg delay_alarm_ff,
    output reg asym_alarm_ff,
    output reg hold_active_ff,
    output reg [`LDS_SLOPE_W-1:0] bias_slope_ff,
    output reg link_fail_ff,
    output reg proto_active_ff,
    output reg rate_active_ff,
    output reg [3:0] mux_n_active_ff
);
    wire dvalid;
    wire [W-1:0] dval;
    reg have_prev_ff;
    reg [W-1:0] prev_ff;
    reg [`LDS_HOLD_W-1:0] hold_ff;
    reg run_at_fail_ff;
    reg fail_d_ff;
    reg [`LDS_HOLD_W-1:0] wd_ff;
    reg [`LDS_HOLD_W-1:0] hold_len;
    reg [W-1:0] diff;
    reg [W-1:0] asym;
    reg [W-1:0] thr;
    reg [3:0] n_eff;
    reg change;
    reg recover;
    // Limits held at full integer width, then cut to the time width
    wire [31:0] thr_min_w = `LDS_THR_MIN_US;
    wire [31:0] thr_max_w = `LDS_THR_MAX_US;
    wire [31:0] asym_max_w = `LDS_ASYM_MAX_US;
    wire [W-1:0] thr_min = thr_min_w[W-1:0];
    wire [W-1:0] thr_max = thr_max_w[W-1:0];
    wire [W-1:0] asym_max = asym_max_w[W-1:0];

    lds_delay_calc #(.W(W)) u_calc (
        .clk(clk),
        .resetn(resetn),
        .msg_valid(msg_valid && !chan_fail),
        .fwd_us(forward_transit_time),
        .ret_us(return_transit_time),
        .delay_valid_ff(dvalid),
        .delay_ff(dval)
    );

    always @* begin
        // Threshold clamped to its settable range
        thr = delay_threshold_us;
        if (thr < thr_min) begin
            thr = thr_min;
        end else if (thr > thr_max) begin
            thr = thr_max;
        end
        diff = (dval > prev_ff) ? dval - prev_ff : prev_ff - dval;
        change = dvalid && have_prev_ff && (diff > thr);
        asym = (forward_transit_time > return_transit_time) ?
            forward_transit_time - return_transit_time :
            return_transit_time - forward_transit_time;
        recover = fail_d_ff && !chan_fail && run_at_fail_ff;
        hold_len = (hold_cycles == {`LDS_HOLD_W{1'b0}}) ? HOLD_CYC : hold_cycles;
        n_eff = (mux_n_sel == `LDS_N_AUTO) ? mux_n_detect : mux_n_sel;
        if (n_eff < `LDS_N_MIN) begin
            n_eff = `LDS_N_MIN;
        end else if (n_eff > `LDS_N_MAX) begin
            n_eff = `LDS_N_MAX;
        end
    end

    // Delay tracking and alarms
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            have_prev_ff <= 1'b0;
            prev_ff <= {W{1'b0}};
            prop_delay_ff <= {W{1'b0}};
            delay_alarm_ff <= 1'b0;
            asym_alarm_ff <= 1'b0;
        end else begin
            if (dvalid) begin
                have_prev_ff <= 1'b1;
                prev_ff <= dval;
                prop_delay_ff <= dval;
            end
            delay_alarm_ff <= change || (delay_alarm_ff && hold_ff != {`LDS_HOLD_W{1'b0}});
            if (msg_valid && !chan_fail) begin
                // Symmetry only matters without external sync
                asym_alarm_ff <= !ext_sync && (asym > asym_max);
            end
        end
    end

    // Hold timer and slope
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            hold_ff <= {`LDS_HOLD_W{1'b0}};
            hold_active_ff <= 1'b0;
            bias_slope_ff <= {`LDS_SLOPE_W{1'b0}};
            run_at_fail_ff <= 1'b0;
            fail_d_ff <= 1'b0;
        end else begin
            fail_d_ff <= chan_fail;
            if (chan_fail && !fail_d_ff) begin
                run_at_fail_ff <= (hold_ff != {`LDS_HOLD_W{1'b0}});
            end else if (recover) begin
                run_at_fail_ff <= 1'b0;
            end
            if (change || recover) begin
                hold_ff <= hold_len;
                hold_active_ff <= 1'b1;
                bias_slope_ff <= `LDS_SLOPE_RAISED;
            end else if (hold_ff > {{(`LDS_HOLD_W-1){1'b0}}, 1'b1}) begin
                hold_ff <= hold_ff - 1'b1;
                hold_active_ff <= 1'b1;
                bias_slope_ff <= `LDS_SLOPE_RAISED;
            end else begin
                hold_ff <= {`LDS_HOLD_W{1'b0}};
                hold_active_ff <= 1'b0;
                bias_slope_ff <= normal_bias_slope;
            end
        end
    end

    // Link integrity watchdog
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wd_ff <= {`LDS_HOLD_W{1'b0}};
            link_fail_ff <= 1'b0;
        end else begin
            if (msg_valid && !chan_fail) begin
                wd_ff <= {`LDS_HOLD_W{1'b0}};
                link_fail_ff <= 1'b0;
            end else if (wd_ff >= LINK_TO_CYC || chan_fail) begin
                link_fail_ff <= 1'b1;
            end else begin
                wd_ff <= wd_ff + 1'b1;
            end
        end
    end

    // Protocol captured once after reset release; rate follows rate_sel in standard mode, N follows n_eff in mux mode
    reg cfg_done_ff;
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cfg_done_ff <= 1'b0;
            proto_active_ff <= `LDS_PROTO_STD;
            rate_active_ff <= `LDS_RATE_64K;
            mux_n_active_ff <= `LDS_N_MIN;
        end else begin
            if (!cfg_done_ff) begin
                cfg_done_ff <= 1'b1;
                proto_active_ff <= proto_sel;
            end
            if ((cfg_done_ff ? proto_active_ff : proto_sel) == `LDS_PROTO_MUX) begin
                rate_active_ff <= `LDS_RATE_64K;
                mux_n_active_ff <= n_eff;
            end else begin
                rate_active_ff <= rate_sel;
                mux_n_active_ff <= `LDS_N_MIN;
            end
        end
    end
endmodule // lds_top

// >>> lds_defs.vh
/*
 Constants for the link delay supervisor: timing, widths and slope codes.
 Assumes inclusion by lds_top.v and lds_delay_calc.v only.
*/
// Operation
// - Delay is half of forward plus return
// - Alarm when successive delays differ by more than threshold
// - Hold timer running selects 200 percent slope
// - Delay change starts the hold timer
// - Further change reloads running hold timer
// - Channel recovery restarts timer if running
// - External sync removes symmetry requirement
// - Link integrity checked continuously
// - Non-mux modes select 64 or 56 kbit/s
// - Mux optical mode runs N x 64, N 1..12
// - Protocol change applies after power cycle
`ifndef LDS_DEFS_VH
`define LDS_DEFS_VH

`define LDS_CLK_MHZ 50
`define LDS_THR_MIN_US 250
`define LDS_THR_MAX_US 1000
`define LDS_ASYM_MAX_US 1000
`define LDS_HOLD_MS_DEF 1000
`define LDS_HOLD_CYC_DEF (`LDS_HOLD_MS_DEF * 1000 * `LDS_CLK_MHZ)
`define LDS_TIME_W 20
`define LDS_HOLD_W 32
`define LDS_SLOPE_W 8
`define LDS_SLOPE_RAISED 8'hC8
`define LDS_RATE_64K 1'b0
`define LDS_RATE_56K 1'b1
`define LDS_PROTO_STD 1'b0
`define LDS_PROTO_MUX 1'b1
`define LDS_N_MIN 4'h1
`define LDS_N_MAX 4'hC
`define LDS_N_AUTO 4'h0
`define LDS_LINK_TO_US 2000

`endif

// >>> lds_delay_calc.v
/*
 Propagation delay from forward and return transit times, in microseconds.
 Assumes transit times are valid in the cycle of msg_valid.
*/
`timescale 1ns/1ps
`include "lds_defs.vh"
module lds_delay_calc #(
    parameter W = `LDS_TIME_W
) (
    // Clock and reset
    input wire clk,
    input wire resetn,
    // Message
    input wire msg_valid,
    input wire [W-1:0] fwd_us,
    input wire [W-1:0] ret_us,
    // Result
    output reg delay_valid_ff,
    output reg [W-1:0] delay_ff
);
    wire [W:0] sum = {1'b0, fwd_us} + {1'b0, ret_us};
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            delay_valid_ff <= 1'b0;
            delay_ff <= {W{1'b0}};
        end else begin
            delay_valid_ff <= msg_valid;
            if (msg_valid) begin
                delay_ff <= sum[W:1];
            end
        end
    end
endmodule // lds_delay_calc

// >>> lds_top_asserts.sv
/* Assertions on the ports of lds_top.
 Assumes the bind below and a single clock domain. */
`timescale 1ns/1ps
module lds_top_asserts #(
    parameter W = 20,
    parameter [31:0] HOLD_CYC = 32'h1,
    parameter [31:0] LINK_TO_CYC = 32'h1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Inputs
    input wire logic msg_valid,
    input wire logic [W-1:0] forward_transit_time,
    input wire logic [W-1:0] return_transit_time,
    input wire logic chan_fail,
    input wire logic ext_sync,
    input wire logic [7:0] normal_bias_slope,
    // Outputs
    input wire logic [W-1:0] prop_delay_ff,
    input wire logic asym_alarm_ff,
    input wire logic hold_active_ff,
    input wire logic [7:0] bias_slope_ff,
    input wire logic link_fail_ff
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    logic [31:0] q_ff;
    logic cf_ff;
    logic ran_ff;
    // Quiet time, and timer state when the channel failed
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            q_ff <= 32'h0;
            cf_ff <= 1'b0;
            ran_ff <= 1'b0;
        end else begin
            q_ff <= (msg_valid || chan_fail) ? 32'h0 : q_ff + 32'h1;
            cf_ff <= chan_fail;
            if (chan_fail && !cf_ff) ran_ff <= hold_active_ff;
        end
    end
    sequence s_taken;
        msg_valid && !chan_fail;
    endsequence
    sequence s_back;
        !chan_fail && cf_ff && ran_ff;
    endsequence
    property p_delay;
        logic [W:0] s;
        (s_taken, s = forward_transit_time + return_transit_time)
            |-> ##2 prop_delay_ff == s[W:1];
    endproperty
    AST_DELAY: assert property (p_delay)
        else $error("bad delay");
    AST_RAISED: assert property (hold_active_ff |-> bias_slope_ff == 8'hC8)
        else $error("slope not raised");
    AST_NORMAL: assert property ($fell(hold_active_ff) |-> bias_slope_ff == normal_bias_slope)
        else $error("slope not restored");
    AST_HOLD_MIN: assert property ($rose(hold_active_ff) |-> hold_active_ff[*8])
        else $error("hold too short");
    AST_HOLD_MAX: assert property (hold_active_ff |-> q_ff <= HOLD_CYC + 6)
        else $error("hold too long");
    AST_RECOVER: assert property (s_back |-> ##[1:2] hold_active_ff[*8])
        else $error("no restart");
    AST_LINK: assert property (q_ff > LINK_TO_CYC + 3 |-> link_fail_ff)
        else $error("link not failed");
    AST_ASYM: assert property (msg_valid && !chan_fail && ext_sync |=> !asym_alarm_ff)
        else $error("asym with sync");
endmodule // lds_top_asserts

bind lds_top lds_top_asserts #(.W(W), .HOLD_CYC(HOLD_CYC), .LINK_TO_CYC(LINK_TO_CYC))
    lds_top_asserts_i (.*);

// >>> lds_remote_end.sv
/* Remote relay end: one message per request, path plus skew.
 Assumes go is driven just after a rising edge. */
`timescale 1ns/1ps
module lds_remote_end (
    // Clock
    input wire logic clk,
    // Request
    input wire logic go,
    input wire logic [19:0] path_us,
    input wire logic [19:0] skew_us,
    // Message
    output logic msg_valid = 1'b0,
    output logic [19:0] forward_transit_time = 20'h0,
    output logic [19:0] return_transit_time = 20'h0
);
    // Skew stays small unless the bench asks; idle lines toggle
    always @(posedge clk) begin
        msg_valid <= go;
        forward_transit_time <= go ? path_us + skew_us : ~forward_transit_time;
        return_transit_time <= go ? path_us : ~return_transit_time;
    end
endmodule // lds_remote_end

// >>> tb_lds_top.sv
/* Testbench for lds_top with a remote end model.
 Assumes lds_remote_end and the bound checker. */
`timescale 1ns/1ps
module tb_lds_top;
    logic clk, resetn, go, chan_fail, ext_sync, rate_sel, proto_sel, msg_valid;
    logic delay_alarm_ff, asym_alarm_ff, hold_active_ff, link_fail_ff;
    logic proto_active_ff, rate_active_ff;
    logic [19:0] path_us, skew_us, forward_transit_time, return_transit_time;
    logic [19:0] delay_threshold_us, prop_delay_ff;
    logic [31:0] hold_cycles;
    logic [7:0] normal_bias_slope, bias_slope_ff;
    logic [3:0] mux_n_sel, mux_n_detect, mux_n_active_ff;
    int fail_count, samples_checked, cycles;
    lds_remote_end lds_remote_end_i (.*);
    lds_top #(.HOLD_CYC(32'h14), .LINK_TO_CYC(32'h32)) lds_top_i (.*);
    task automatic chk(string n, logic [31:0] s, logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            fail_count++;
            $display("mismatch %s exp %0h seen %0h", n, e, s);
        end
    endtask
    task automatic idle(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic send(logic [19:0] p, logic [19:0] k);
        idle(1);
        go = 1'b1;
        path_us = p;
        skew_us = k;
        idle(1);
        go = 1'b0;
        idle(3);
    endtask
    task automatic do_reset;
        resetn = 1'b0;
        idle(6);
        resetn = 1'b1;
        idle(2);
    endtask
    task automatic report_and_stop;
        if (fail_count == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            report_and_stop;
        end
    end
    initial begin
        {go, chan_fail, proto_sel} = 3'h0;
        {ext_sync, rate_sel} = 2'h3;
        {path_us, skew_us} = 40'h0;
        delay_threshold_us = 20'h12C;
        hold_cycles = 32'h14;
        normal_bias_slope = 8'h64;
        mux_n_sel = 4'h0;
        mux_n_detect = 4'h5;
        do_reset;
        proto_sel = 1'b1;
        idle(2);
        chk("proto", proto_active_ff, 0);
        chk("rate", rate_active_ff, 1);
        send(20'h7D0, 20'h0);
        chk("delay", prop_delay_ff, 20'h7D0);
        chk("alarm", delay_alarm_ff, 0);
        send(20'h7D0, 20'hBB9);
        chk("delay", prop_delay_ff, 20'hDAC);
        chk("alarm", delay_alarm_ff, 1);
        chk("slope", bias_slope_ff, 8'hC8);
        chk("asym", asym_alarm_ff, 0);
        idle(8);
        send(20'h1388, 20'h0);
        idle(12);
        chk("hold", hold_active_ff, 1);
        idle(10);
        chk("hold", hold_active_ff, 0);
        chk("slope", bias_slope_ff, 8'h64);
        send(20'h1450, 20'h0);
        chk("alarm", delay_alarm_ff, 0);
        ext_sync = 1'b0;
        send(20'h7D0, 20'h5DC);
        chk("asym", asym_alarm_ff, 1);
        chk("hold", hold_active_ff, 1);
        chan_fail = 1'b1;
        idle(40);
        chk("link", link_fail_ff, 1);
        chan_fail = 1'b0;
        idle(4);
        chk("hold", hold_active_ff, 1);
        idle(60);
        chk("link", link_fail_ff, 1);
        send(20'h7D0, 20'h0);
        chk("link", link_fail_ff, 0);
        idle(40);
        chk("link", link_fail_ff, 0);
        idle(20);
        chk("link", link_fail_ff, 1);
        do_reset;
        chk("proto", proto_active_ff, 1);
        chk("rate", rate_active_ff, 0);
        chk("n", mux_n_active_ff, 4'h5);
        mux_n_sel = 4'hD;
        idle(2);
        chk("n", mux_n_active_ff, 4'hC);
        mux_n_sel = 4'h3;
        idle(2);
        chk("n", mux_n_active_ff, 4'h3);
        report_and_stop;
    end
endmodule // tb_lds_top
